// *** shared/blm_pkg.sv ***
package blm_pkg;

    // organisation defaults: 18-bit word in two 9-bit lanes
    localparam int DATA_W_DEF     = 18;
    localparam int LANES_DEF      = 2;
    // modelled depth only; a full-size array is far deeper
    localparam int ADDR_W_DEF     = 8;
    localparam int FIFO_DEPTH_DEF = 8;

    // burst of four beats, counted 0..3
    localparam int         BURST_BEATS = 4;
    localparam int         BEAT_CNT_W  = 2;
    localparam logic [1:0] BEAT_FIRST  = 2'h0;
    localparam logic [1:0] BEAT_LAST   = 2'h3;

    // reset values of control state
    localparam logic PIN_RST     = 1'h0;
    localparam logic WPS_PREV_RST = 1'h0;
    localparam logic PEND_RST    = 1'h0;
    localparam logic FLAG_RST    = 1'h0;

    typedef enum logic {
        BLM_IDLE,
        BLM_BURST
    } blm_state_t;

endpackage : blm_pkg

// *** rtl/blm_fifo.sv ***
`timescale 1ns/1ns
module blm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = blm_pkg::FIFO_DEPTH_DEF
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    import blm_pkg::*;

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW:0]      wr_ptr_r;
    logic [AW:0]      rd_ptr_r;

    wire full  = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                 (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    wire empty = (wr_ptr_r == rd_ptr_r);
    wire push  = in_valid && !full;
    wire pop   = out_ready && !empty;

    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = store[rd_ptr_r[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            store[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + (AW+1)'(1);
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + (AW+1)'(1);
            end
        end
    end

    a_fifo_full_holds: assert property (@(posedge clk) disable iff (!rst_n)
        full && !pop |=> full && $stable(wr_ptr_r))
        else $error("fifo write pointer moved while full");

    a_fifo_empty_holds: assert property (@(posedge clk) disable iff (!rst_n)
        empty && !push |=> empty && $stable(rd_ptr_r))
        else $error("fifo read pointer moved while empty");

endmodule : blm_fifo

// *** rtl/blm_mem.sv ***
`timescale 1ns/1ns
module blm_mem #(
    parameter int DATA_W = blm_pkg::DATA_W_DEF,
    parameter int ADDR_W = blm_pkg::ADDR_W_DEF
) (
    // clock
    input  wire logic              clk,
    // masked write port
    input  wire logic              we,
    input  wire logic [ADDR_W-1:0] waddr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic [DATA_W-1:0] wmask,
    // registered read port
    input  wire logic              re,
    input  wire logic [ADDR_W-1:0] raddr,
    output logic      [DATA_W-1:0] rdata
);
    import blm_pkg::*;

    logic [DATA_W-1:0] array [2**ADDR_W];

    // bits outside the mask keep the stored value
    wire [DATA_W-1:0] merged = (array[waddr] & ~wmask) | (wdata & wmask);

    always_ff @(posedge clk) begin
        if (we) begin
            array[waddr] <= merged;
        end
        if (re) begin
            rdata <= array[raddr];
        end
    end

endmodule : blm_mem

// *** rtl/blm_burst_write.sv ***
`timescale 1ns/1ns
module blm_burst_write #(
    parameter int DATA_W     = blm_pkg::DATA_W_DEF,
    parameter int LANES      = blm_pkg::LANES_DEF,
    parameter int ADDR_W     = blm_pkg::ADDR_W_DEF,
    parameter int FIFO_DEPTH = blm_pkg::FIFO_DEPTH_DEF
) (
    // clock and reset
    input  wire logic              CLOCK,
    input  wire logic              RESET_N,
    // write port pins from the memory controller
    input  wire logic              K,
    input  wire logic              K_N,
    input  wire logic              WRITE_PORT_SEL_N,
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [DATA_W-1:0] DATA,
    input  wire logic [LANES-1:0]  LANE_WRITE_SELECT_N,
    // local read-back port
    input  wire logic              RD_EN,
    input  wire logic [ADDR_W-1:0] RD_ADDR,
    output logic      [DATA_W-1:0] RD_DATA,
    output logic                   RD_VALID,
    // status
    output logic                   BURST_ACTIVE,
    output logic                   FIFO_READY,
    output logic                   BEAT_OVERRUN
);
    import blm_pkg::*;

    localparam int LANE_W  = DATA_W / LANES;
    localparam int PIN_W   = 3 + ADDR_W + LANES + DATA_W;
    localparam int ENTRY_W = ADDR_W + LANES + DATA_W;

    // expand active-low lane selects to a per-bit write mask
    function automatic logic [DATA_W-1:0] lane_mask(
        input logic [LANES-1:0] sel_n
    );
        logic [DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < DATA_W; i++) begin
            m[i] = ~sel_n[i / LANE_W];
        end
        return m;
    endfunction : lane_mask

    // three-stage pin synchroniser
    logic [PIN_W-1:0] pin_s0_r;
    logic [PIN_W-1:0] pin_s1_r;
    logic [PIN_W-1:0] pin_s2_r;
    logic             k_lvl_r;
    logic             kn_lvl_r;

    // control state
    blm_state_t        state_r;
    blm_state_t        state_nxt;
    logic [1:0]        beat_r;
    logic [1:0]        beat_nxt;
    logic [ADDR_W-1:0] base_r;
    logic [ADDR_W-1:0] base_nxt;
    logic              pend_r;
    logic              pend_nxt;
    logic [ADDR_W-1:0] pend_addr_r;
    logic [ADDR_W-1:0] pend_addr_nxt;
    logic              wps_prev_r;

    // output flops
    logic              rd_valid_r;
    logic              burst_active_r;
    logic              fifo_ready_r;
    logic              overrun_r;

    // fifo and memory hookup
    logic               fifo_in_ready;
    logic               fifo_out_valid;
    logic [ENTRY_W-1:0] fifo_out_data;
    logic [DATA_W-1:0]  mem_rdata;

    wire [PIN_W-1:0] pin_raw = {K, K_N, WRITE_PORT_SEL_N, ADDR,
                                LANE_WRITE_SELECT_N, DATA};

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            pin_s0_r <= '0;
            pin_s1_r <= '0;
            pin_s2_r <= '0;
        end else begin
            pin_s0_r <= pin_raw;
            pin_s1_r <= pin_s0_r;
            pin_s2_r <= pin_s1_r;
        end
    end

    // synchronised fields aligned on the third stage; k_s1 and kn_s1 tap the second stage
    wire               k_s1    = pin_s1_r[PIN_W-1];
    wire               k_s2    = pin_s2_r[PIN_W-1];
    wire               kn_s1   = pin_s1_r[PIN_W-2];
    wire               kn_s2   = pin_s2_r[PIN_W-2];
    wire               wps_n_s = pin_s2_r[PIN_W-3];
    wire [ADDR_W-1:0]  addr_s  = pin_s2_r[DATA_W+LANES +: ADDR_W];
    wire [LANES-1:0]   sel_s   = pin_s2_r[DATA_W +: LANES];
    wire [DATA_W-1:0]  data_s  = pin_s2_r[DATA_W-1:0];

    wire k_agree  = (k_s1 == k_s2);
    wire kn_agree = (kn_s1 == kn_s2);
    wire k_rise   = k_agree && k_s2 && !k_lvl_r;
    wire kn_rise  = kn_agree && kn_s2 && !kn_lvl_r;

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            k_lvl_r  <= PIN_RST;
            kn_lvl_r <= PIN_RST;
        end else begin
            if (k_agree) begin
                k_lvl_r <= k_s2;
            end
            if (kn_agree) begin
                kn_lvl_r <= kn_s2;
            end
        end
    end

    // a write on the previous true-clock rise blocks this one
    wire cmd_ok = k_rise && !wps_n_s && !wps_prev_r;

    // even beats on true clock, odd beats on inverted clock
    wire beat_edge = (state_r == BLM_BURST) &&
                     (beat_r[0] ? kn_rise : k_rise);
    wire last_beat = beat_edge && (beat_r == BEAT_LAST);

    wire [ADDR_W-1:0] beat_addr = base_r + ADDR_W'(beat_r);

    // fully masked beats never enter the write path
    wire sel_all_high = &sel_s;
    // selects taken afresh on every beat edge
    wire beat_want    = beat_edge && !sel_all_high;
    wire beat_push    = beat_want && fifo_in_ready;
    wire beat_lost    = beat_want && !fifo_in_ready;

    always_comb begin
        state_nxt     = state_r;
        beat_nxt      = beat_r;
        base_nxt      = base_r;
        pend_nxt      = pend_r;
        pend_addr_nxt = pend_addr_r;
        if (beat_edge) begin
            beat_nxt = beat_r + 2'h1;
        end
        case (state_r)
            BLM_IDLE: begin
                if (cmd_ok) begin
                    state_nxt = BLM_BURST;
                    beat_nxt  = BEAT_FIRST;
                    base_nxt  = addr_s;
                end
            end
            BLM_BURST: begin
                // next burst may be latched before this one drains
                if (cmd_ok) begin
                    pend_nxt      = 1'b1;
                    pend_addr_nxt = addr_s;
                end
                if (last_beat) begin
                    if (pend_r) begin
                        beat_nxt = BEAT_FIRST;
                        base_nxt = pend_addr_r;
                        pend_nxt = 1'b0;
                    end else begin
                        state_nxt = BLM_IDLE;
                    end
                end
            end
            default: begin
                state_nxt = BLM_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_r     <= BLM_IDLE;
            beat_r      <= BEAT_FIRST;
            base_r      <= '0;
            pend_r      <= PEND_RST;
            pend_addr_r <= '0;
            wps_prev_r  <= WPS_PREV_RST;
        end else begin
            state_r     <= state_nxt;
            beat_r      <= beat_nxt;
            base_r      <= base_nxt;
            pend_r      <= pend_nxt;
            pend_addr_r <= pend_addr_nxt;
            if (k_rise) begin
                wps_prev_r <= !wps_n_s;
            end
        end
    end

    // reads take the array, so writes wait and the fifo can fill
    wire fifo_out_ready = !RD_EN;
    wire mem_we         = fifo_out_valid && fifo_out_ready;

    wire [ADDR_W-1:0] pop_addr = fifo_out_data[DATA_W+LANES +: ADDR_W];
    wire [LANES-1:0]  pop_sel  = fifo_out_data[DATA_W +: LANES];
    wire [DATA_W-1:0] pop_data = fifo_out_data[DATA_W-1:0];
    // mask built from the beat's own selects only
    wire [DATA_W-1:0] pop_mask = lane_mask(pop_sel);

    blm_fifo #(
        .WIDTH (ENTRY_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (CLOCK),
        .rst_n     (RESET_N),
        .in_valid  (beat_want),
        .in_ready  (fifo_in_ready),
        .in_data   ({beat_addr, sel_s, data_s}),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    blm_mem #(
        .DATA_W (DATA_W),
        .ADDR_W (ADDR_W)
    ) u_mem (
        .clk   (CLOCK),
        .we    (mem_we),
        .waddr (pop_addr),
        .wdata (pop_data),
        .wmask (pop_mask),
        .re    (RD_EN),
        .raddr (RD_ADDR),
        .rdata (mem_rdata)
    );

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            rd_valid_r     <= FLAG_RST;
            burst_active_r <= FLAG_RST;
            fifo_ready_r   <= FLAG_RST;
            overrun_r      <= FLAG_RST;
        end else begin
            rd_valid_r     <= RD_EN;
            burst_active_r <= (state_nxt == BLM_BURST);
            fifo_ready_r   <= fifo_in_ready;
            overrun_r      <= beat_lost;
        end
    end

    assign RD_DATA      = mem_rdata;
    assign RD_VALID     = rd_valid_r;
    assign BURST_ACTIVE = burst_active_r;
    assign FIFO_READY   = fifo_ready_r;
    assign BEAT_OVERRUN = overrun_r;

    // helper patterns for the checks below
    wire [LANES-1:0]  lo_only_sel = ~LANES'(1);
    wire [LANES-1:0]  hi_only_sel = ~(LANES'(1) << (LANES-1));
    wire [DATA_W-1:0] lo_lane_msk = DATA_W'({LANE_W{1'b1}});
    wire [DATA_W-1:0] hi_lane_msk = lo_lane_msk << (DATA_W-LANE_W);

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RESET_N);

    a_full_word_mask: assert property (
        mem_we && (pop_sel == '0) |-> (pop_mask == '1))
        else $error("all selects low did not write the whole word");

    a_low_lane_mask: assert property (
        mem_we && (pop_sel == lo_only_sel) |-> (pop_mask == lo_lane_msk))
        else $error("lone select 0 did not write only the low lane");

    a_high_lane_mask: assert property (
        mem_we && (pop_sel == hi_only_sel) |-> (pop_mask == hi_lane_msk))
        else $error("lone top select did not write only the top lane");

    a_masked_beat_drop: assert property (
        beat_edge && sel_all_high |-> !beat_push ##1 !overrun_r)
        else $error("fully masked beat reached the write path");

    a_each_beat_taken: assert property (
        beat_edge && !sel_all_high && fifo_in_ready
        |=> $changed(u_fifo.wr_ptr_r))
        else $error("beat with an active select was not queued");

    a_burst_edge_order: assert property (
        state_r == BLM_IDLE ##1 state_r == BLM_BURST
        |-> beat_r == BEAT_FIRST && !pend_r)
        else $error("burst did not open on its first beat");

    a_burst_closes: assert property (
        last_beat && !pend_r |=> state_r == BLM_IDLE && !burst_active_r
        ##1 !burst_active_r || state_r == BLM_BURST)
        else $error("burst did not close after its fourth beat");

    a_beat_address: assert property (
        beat_edge |-> beat_addr == base_r + ADDR_W'(beat_r)
        ##1 (state_r == BLM_IDLE || beat_r != $past(beat_r)))
        else $error("beat address or beat count wrong");

    a_mask_per_beat: assert property (
        mem_we |=> (((u_mem.array[$past(pop_addr)] ^ $past(pop_data))
                     & $past(pop_mask)) == '0) &&
                   (((u_mem.array[$past(pop_addr)]
                      ^ $past(u_mem.array[pop_addr]))
                     & ~$past(pop_mask)) == '0))
        else $error("write mask carried lanes from another beat");

    c_full_burst: cover property (
        last_beat ##1 state_r == BLM_IDLE);
    c_masked_beat: cover property (
        beat_edge && sel_all_high);
    c_fifo_fills: cover property (
        !fifo_in_ready);
    c_chained_burst: cover property (
        last_beat && pend_r);

endmodule : blm_burst_write

// *** test/blm_ctl_model.sv ***
`timescale 1ns/1ns
module blm_ctl_model #(
    parameter int DATA_W = 18,
    parameter int LANES  = 2,
    parameter int ADDR_W = 8
) (
    // system clock
    input  wire logic              clk,
    // write port pins toward the memory
    output logic                   k,
    output logic                   k_n,
    output logic                   wsel_n,
    output logic      [ADDR_W-1:0] addr,
    output logic      [DATA_W-1:0] data,
    output logic      [LANES-1:0]  lane_n
);
    initial begin
        k      = 1'h0;
        k_n    = 1'h0;
        wsel_n = 1'h1;
        addr   = '0;
        data   = '0;
        lane_n = '1;
    end

    // one half period: 4 cycles setup, 4 hold, for the pin synchroniser
    task automatic half(input logic [DATA_W-1:0] d,
                        input logic [LANES-1:0]  s,
                        input logic              w,
                        input logic [ADDR_W-1:0] a);
        @(posedge clk);
        data   <= d;
        lane_n <= s;
        wsel_n <= w;
        addr   <= a;
        repeat (4) @(posedge clk);
        k   <= ~k;
        k_n <= k;
        repeat (3) @(posedge clk);
    endtask : half

    // hold keeps the request low on the next k rise as well
    task automatic burst(input logic [ADDR_W-1:0]   a,
                         input logic [4*DATA_W-1:0] d,
                         input logic [4*LANES-1:0]  s,
                         input logic                hold);
        half(~data, ~lane_n, 1'h0, a);
        // released lines show the inverse, not a stale value
        half(~data, ~lane_n, ~hold, ~a);
        for (int i = 0; i < 4; i++) begin
            half(d[i*DATA_W +: DATA_W], s[i*LANES +: LANES],
                 (i == 0) ? ~hold : 1'h1, ~a);
        end
        @(posedge clk);
        data   <= ~data;
        lane_n <= ~lane_n;
        addr   <= a;
    endtask : burst
endmodule : blm_ctl_model

// *** test/burst_write_lane_masking_tb_top.sv ***
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
    begin \
        n_tests++; \
        if ((got) !== (ex)) begin \
            mismatches++; \
            $display("unexpected %s: expected %h seen %h", nm, ex, got); \
        end \
    end
module burst_write_lane_masking_tb_top;
    import blm_pkg::*;
    localparam int DW = DATA_W_DEF;
    localparam int LN = LANES_DEF;
    localparam int AW = ADDR_W_DEF;
    localparam int LW = DW / LN;

    typedef struct packed {
        logic [AW-1:0]   a;
        logic [4*DW-1:0] d;
        logic [4*LN-1:0] s;
    } blm_row_t;

    // per-beat selects: beat 0 in the low bits
    localparam blm_row_t ROWS [4] = '{
        '{8'h10, 72'h12_3456_789a_bcde_f012, 8'h00},
        '{8'hfe, 72'hfe_dcba_9876_5432_10fe, 8'h00},
        '{8'h10, 72'h5a_a5a5_5a5a_a5a5_5a5a, 8'h36},
        '{8'hfe, 72'h0f_0f0f_f0f0_0f0f_f0f0, 8'h63}
    };
    localparam logic [4*DW-1:0] D = 72'h3c_1234_c3c3_8765_4321;

    logic          CLOCK;
    logic          RESET_N;
    logic          K;
    logic          K_N;
    logic          WRITE_PORT_SEL_N;
    logic [AW-1:0] ADDR;
    logic [DW-1:0] DATA;
    logic [LN-1:0] LANE_WRITE_SELECT_N;
    logic          RD_EN;
    logic [AW-1:0] RD_ADDR;
    logic [DW-1:0] RD_DATA;
    logic          RD_VALID;
    logic          BURST_ACTIVE;
    logic          FIFO_READY;
    logic          BEAT_OVERRUN;
    logic [DW-1:0] exp_mem [2**AW];
    logic          ovr_seen = 1'h0;
    logic          act_seen = 1'h0;
    wire  [3:0]    status = {RD_VALID, BURST_ACTIVE,
                             FIFO_READY, BEAT_OVERRUN};
    int            mismatches = 0;
    int            n_tests = 0;

    blm_ctl_model #(.DATA_W(DW), .LANES(LN), .ADDR_W(AW)) u_ctl (
        .clk    (CLOCK),
        .k      (K),
        .k_n    (K_N),
        .wsel_n (WRITE_PORT_SEL_N),
        .addr   (ADDR),
        .data   (DATA),
        .lane_n (LANE_WRITE_SELECT_N)
    );

    blm_burst_write #(.DATA_W(DW), .LANES(LN), .ADDR_W(AW)) DUT (
        .CLOCK               (CLOCK),
        .RESET_N             (RESET_N),
        .K                   (K),
        .K_N                 (K_N),
        .WRITE_PORT_SEL_N    (WRITE_PORT_SEL_N),
        .ADDR                (ADDR),
        .DATA                (DATA),
        .LANE_WRITE_SELECT_N (LANE_WRITE_SELECT_N),
        .RD_EN               (RD_EN),
        .RD_ADDR             (RD_ADDR),
        .RD_DATA             (RD_DATA),
        .RD_VALID            (RD_VALID),
        .BURST_ACTIVE        (BURST_ACTIVE),
        .FIFO_READY          (FIFO_READY),
        .BEAT_OVERRUN        (BEAT_OVERRUN)
    );

    always #50 CLOCK = ~CLOCK;

    always @(posedge CLOCK) begin
        if (BEAT_OVERRUN === 1'h1) begin
            ovr_seen <= 1'h1;
        end
        if (BURST_ACTIVE === 1'h1) begin
            act_seen <= 1'h1;
        end
    end

    function automatic logic [DW-1:0] lane_mask(input logic [LN-1:0] s);
        lane_mask = '0;
        for (int i = 0; i < LN; i++) begin
            if (s[i] == 1'b0) begin
                lane_mask[i*LW +: LW] = '1;
            end
        end
    endfunction : lane_mask

    // reference: low select writes its lane, the rest is kept
    function automatic void apply(input blm_row_t r);
        logic [AW-1:0] a;
        logic [DW-1:0] m;
        for (int b = 0; b < 4; b++) begin
            a = AW'(r.a + b);
            m = lane_mask(r.s[b*LN +: LN]);
            exp_mem[a] = (exp_mem[a] & ~m) | (r.d[b*DW +: DW] & m);
        end
    endfunction : apply

    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] q);
        @(posedge CLOCK);
        RD_EN   <= 1'h1;
        RD_ADDR <= a;
        @(posedge CLOCK);
        RD_EN   <= 1'h0;
        // valid stands for one cycle only, right after the request
        @(negedge CLOCK);
        `CHK("read valid", 1'h1, RD_VALID)
        q = RD_DATA;
    endtask : rd

    task automatic chk_burst(input logic [AW-1:0] a);
        logic [DW-1:0] q;
        repeat (10) @(posedge CLOCK);
        for (int b = 0; b < 4; b++) begin
            rd(AW'(a + b), q);
            `CHK("stored word", exp_mem[AW'(a + b)], q)
        end
    endtask : chk_burst

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    initial begin
        #2000000;
        mismatches++;
        close_out();
    end

    initial begin
        CLOCK   = 1'h0;
        RESET_N = 1'h0;
        RD_EN   = 1'h0;
        RD_ADDR = '0;
        repeat (4) @(posedge CLOCK);
        `CHK("status in reset", 4'h0, status)
        repeat (4) @(posedge CLOCK);
        RESET_N <= 1'h1;
        repeat (10) @(posedge CLOCK);
        `CHK("ready after reset", 1'h1, FIFO_READY)
        // table: full writes, then per-beat masks incl. all high and wrap
        for (int r = 0; r < 4; r++) begin
            u_ctl.burst(ROWS[r].a, ROWS[r].d, ROWS[r].s, 1'h0);
            apply(ROWS[r]);
            chk_burst(ROWS[r].a);
        end
        `CHK("burst opened", 1'h1, act_seen)
        // request held low on the next k rise must not open a burst
        u_ctl.burst(8'h20, D, 8'h00, 1'h1);
        apply(blm_row_t'{8'h20, D, 8'h00});
        chk_burst(8'h20);
        `CHK("burst closed", 1'h0, BURST_ACTIVE)
        // stall the writes with reads until the beat buffer refuses
        @(posedge CLOCK);
        RD_EN <= 1'h1;
        u_ctl.burst(8'h40, D, 8'h00, 1'h0);
        u_ctl.burst(8'h44, ~D, 8'h00, 1'h0);
        repeat (8) @(posedge CLOCK);
        @(negedge CLOCK);
        `CHK("buffer full", 1'h0, FIFO_READY)
        `CHK("no beat lost", 1'h0, ovr_seen)
        u_ctl.burst(8'h48, D, 8'h00, 1'h0);
        repeat (8) @(posedge CLOCK);
        `CHK("beat lost", 1'h1, ovr_seen)
        RD_EN <= 1'h0;
        repeat (12) @(posedge CLOCK);
        @(negedge CLOCK);
        `CHK("buffer drained", 1'h1, FIFO_READY)
        apply(blm_row_t'{8'h40, D, 8'h00});
        apply(blm_row_t'{8'h44, ~D, 8'h00});
        chk_burst(8'h40);
        chk_burst(8'h44);
        // mid-run reset while idle: flags clear, stored words survive
        @(posedge CLOCK);
        RESET_N <= 1'h0;
        repeat (2) @(posedge CLOCK);
        `CHK("status in reset", 4'h0, status)
        RESET_N <= 1'h1;
        repeat (4) @(posedge CLOCK);
        `CHK("ready after reset", 1'h1, FIFO_READY)
        `CHK("no burst after reset", 1'h0, BURST_ACTIVE)
        u_ctl.burst(8'h60, ~D, 8'h00, 1'h0);
        apply(blm_row_t'{8'h60, ~D, 8'h00});
        chk_burst(8'h60);
        chk_burst(8'h44);
        close_out();
    end
endmodule : burst_write_lane_masking_tb_top
